// >>> src_pkg.sv
// Constants and types shared by the system reset controller
`default_nettype none
package src_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CAUSE   = 12'h000;
  localparam logic [11:0] OFS_MASK    = 12'h004;
  localparam logic [11:0] OFS_SWRST   = 12'h008;
  localparam logic [11:0] OFS_BODCTL  = 12'h00c;
  localparam logic [11:0] OFS_CLKCTL  = 12'h010;
  localparam logic [11:0] OFS_STATUS  = 12'h014;

  // Cause register layout
  localparam int          CAUSE_W      = 9;
  localparam int          CB_POR       = 0;
  localparam int          CB_PIN       = 1;
  localparam int          CB_WDT       = 2;
  localparam int          CB_BOD       = 4;
  localparam int          CB_MCU       = 5;
  localparam int          CB_CPU       = 7;
  localparam int          CB_LOCKUP    = 8;
  localparam logic [8:0]  CAUSE_PWRUP  = 9'h001;

  // Software reset register bits
  localparam int          SW_CHIP      = 0;
  localparam int          SW_MCU       = 1;
  localparam int          SW_CPU       = 2;

  // Brown-out control layout
  localparam int          BOD_EN       = 0;
  localparam int          BOD_LVL_LO   = 1;
  localparam int          BOD_RSTEN    = 3;

  // Clock control layout and reset values
  localparam int          CLK_XTAL_LO  = 0;
  localparam int          CLK_SEL_LO   = 4;
  localparam int          CLK_WDT      = 8;
  localparam int          CLKSEL_W     = 4;
  localparam logic [1:0]  XTAL_RST     = 2'h0;
  localparam logic [3:0]  CLKSEL_RST   = 4'h8;
  localparam logic        WDTCK_RST    = 1'h1;
  localparam logic        CHIPREQ_RST  = 1'h0;

  // Timing counts, in clock cycles
  localparam int          DEGLITCH_CYC   = 16;
  localparam int          RESET_HOLD_CYC = 4;
  localparam int          CNT_W          = 8;

  typedef enum logic [3:0] {
    SRC_POR    = 4'h0,
    SRC_PIN    = 4'h1,
    SRC_WDT    = 4'h2,
    SRC_LVR    = 4'h3,
    SRC_BOD    = 4'h4,
    SRC_LOCKUP = 4'h5,
    SRC_CHIP   = 4'h6,
    SRC_MCU    = 4'h7,
    SRC_CPU    = 4'h8
  } src_kind_e;

  typedef enum logic [2:0] {
    ST_PWRUP = 3'h0,
    ST_HOLD  = 3'h1,
    ST_PIN   = 3'h2,
    ST_LV    = 3'h3,
    ST_RUN   = 3'h4
  } src_state_e;

endpackage
`default_nettype wire

// >>> src_deglitch.sv
// Level filter for the low-supply comparator
`default_nettype none
`timescale 1ns/10ps
module src_deglitch
  import src_pkg::*;
#(
  parameter int ASSERT_CYC = DEGLITCH_CYC
)
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic raw,
  output logic      filt
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] lim;

  // Release needs strictly longer than the assert interval
  assign lim = filt ? CNT_W'(ASSERT_CYC) : CNT_W'(ASSERT_CYC - 1);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_reg <= '0;
      filt    <= 1'b0;
    end
    else if (raw == filt)
    begin
      cnt_reg <= '0;  // see [R13]
    end
    else if (cnt_reg == lim)
    begin
      filt    <= raw;  // see [R10] see [R11]
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> src_flags.sv
// Sticky write-one-to-clear flag bank
`default_nettype none
`timescale 1ns/10ps
module src_flags
  import src_pkg::*;
#(
  parameter int WIDTH = CAUSE_W
)
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] flags
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (!rst_b)
          flags[i] <= 1'b0;
        else if (load)
          flags[i] <= load_val[i];
        else if (set[i])
          flags[i] <= 1'b1;  // Set beats a same-cycle clear
        else if (clr[i])
          flags[i] <= 1'b0;  // see [R9]
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> src_top.sv
// System reset controller: source arbitration, cause record, APB registers
`default_nettype none
`timescale 1ns/10ps
// Function
// [R1] Nine sources are taken; CPU reset holds only the core, others all.
// [R2] Each reset records its source as a bit of the cause register; chip and low-voltage resets set power-on bit 0 instead.
// [R3] The whole-chip request bit is cleared by power-on reset and by no other reset; a software reset register write with bit 0 at zero also clears it.
// [R4] Brown-out fields reload from the config word except on BROWNOUT_DETECTOR and CPU.
// [R5] Crystal enable clears on every source except CPU reset.
// [R6] Watchdog clock enable is set by power-on, watchdog and chip reset.
// [R7] Clock source select loads 0x8 on every source except CPU reset.
// [R8] Power-up holds everything in reset until supply ready, then flags it.
// [R9] Software clears a cause flag by writing one; zero leaves it.
// [R10] Low supply resets the chip after 16 continuous asserted cycles.
// [R11] Low-voltage reset holds until supply is good for longer than that.
// [R12] A reset from the external pin sets cause bit 1.
// [R13] The de-glitch count restarts whenever the level changes back.
module src_top
  import src_pkg::*;
#(
  parameter int HOLD_CYC = RESET_HOLD_CYC,
  parameter int DEGLITCH = DEGLITCH_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        supply_ready,
  input  wire logic        low_supply,
  input  wire logic        external_reset_pin_b,
  input  wire logic        wdt_reset,
  input  wire logic        bod_reset,
  input  wire logic        core_lockup,
  input  wire logic        cfg_brownout_enable,
  input  wire logic [1:0]  cfg_brownout_level,
  input  wire logic        cfg_brownout_reset_enable,
  output logic             core_reset_b,
  output logic             periph_reset_b,
  output logic             brownout_enable,
  output logic [1:0]       brownout_level,
  output logic             brownout_reset_enable,
  output logic [1:0]       crystal_enable,
  output logic             watchdog_clock_enable,
  output logic [3:0]       system_clock_source_select,
  output logic             irq
);

  src_state_e          state_reg;
  src_state_e          state_next;
  src_kind_e           kind;
  logic                evt;
  logic                lv_filt;
  logic                cpu_only_reg;
  logic                cpu_only_next;
  logic [CNT_W-1:0]    hold_cnt_reg;
  logic [CAUSE_W-1:0]  cause;
  logic [CAUSE_W-1:0]  cause_set;
  logic [CAUSE_W-1:0]  cause_clr;
  logic [CAUSE_W-1:0]  mask_reg;
  logic                chip_req_reg;
  logic                chip_pend_reg;
  logic                mcu_pend_reg;
  logic                cpu_pend_reg;
  logic                setup;
  logic                wr_en;
  logic                mapped;
  logic [31:0]         rdata;

  src_deglitch #(
    .ASSERT_CYC (DEGLITCH)
  ) u_lv (
    .clk   (clk),
    .rst_b (rst_b),
    .raw   (low_supply),
    .filt  (lv_filt)
  );

  // Source arbitration; power loss overrides any state, low voltage any state but power-up
  always_comb
  begin
    state_next = state_reg;
    evt        = 1'b0;
    kind       = SRC_POR;
    case (state_reg)
      ST_PWRUP:
        if (supply_ready)
        begin
          evt        = 1'b1;  // see [R8]
          state_next = ST_HOLD;
        end
      ST_RUN:
        if (!external_reset_pin_b)
        begin
          evt        = 1'b1;
          kind       = SRC_PIN;
          state_next = ST_PIN;
        end
        else if (bod_reset || wdt_reset || core_lockup || chip_pend_reg ||
                 mcu_pend_reg || cpu_pend_reg)
        begin
          evt        = 1'b1;  // see [R1]
          state_next = ST_HOLD;
          if (bod_reset)
            kind = SRC_BOD;
          else if (wdt_reset)
            kind = SRC_WDT;
          else if (core_lockup)
            kind = SRC_LOCKUP;
          else if (chip_pend_reg)
            kind = SRC_CHIP;
          else if (mcu_pend_reg)
            kind = SRC_MCU;
          else
            kind = SRC_CPU;
        end
      ST_PIN:
        if (external_reset_pin_b)
          state_next = ST_HOLD;
      ST_LV:
        if (!lv_filt)
          state_next = ST_HOLD;  // see [R11]
      ST_HOLD:
        if (hold_cnt_reg == CNT_W'(HOLD_CYC - 1))
          state_next = ST_RUN;
      default:
        state_next = ST_PWRUP;
    endcase
    if (lv_filt && state_reg != ST_LV && state_reg != ST_PWRUP)
    begin
      evt        = 1'b1;  // see [R10]
      kind       = SRC_LVR;
      state_next = ST_LV;
    end
    if (!supply_ready)
    begin
      evt        = 1'b0;
      state_next = ST_PWRUP;  // see [R8]
    end
  end

  assign cpu_only_next = evt ? (kind == SRC_CPU) : cpu_only_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg    <= ST_PWRUP;
      cpu_only_reg <= 1'b0;
      hold_cnt_reg <= '0;
    end
    else
    begin
      state_reg    <= state_next;
      cpu_only_reg <= cpu_only_next;
      hold_cnt_reg <= (state_reg == ST_HOLD && !evt) ?
                      hold_cnt_reg + 1'b1 : '0;
    end
  end

  // Reset outputs; CPU-only reset leaves peripherals running
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      core_reset_b   <= 1'b0;
      periph_reset_b <= 1'b0;
    end
    else
    begin
      core_reset_b   <= (state_next == ST_RUN);
      periph_reset_b <= (state_next == ST_RUN) ||
                        (state_next == ST_HOLD && cpu_only_next);  // see [R1]
    end
  end

  // Cause flags
  always_comb
  begin
    cause_set = '0;
    if (evt)
    begin
      case (kind)
        SRC_PIN:    cause_set[CB_PIN]    = 1'b1;  // see [R12]
        SRC_WDT:    cause_set[CB_WDT]    = 1'b1;
        SRC_BOD:    cause_set[CB_BOD]    = 1'b1;
        SRC_LOCKUP: cause_set[CB_LOCKUP] = 1'b1;
        SRC_CHIP:   cause_set[CB_POR]    = 1'b1;
        SRC_MCU:    cause_set[CB_MCU]    = 1'b1;
        SRC_CPU:    cause_set[CB_CPU]    = 1'b1;
        default:    cause_set            = '0;
      endcase
    end
  end

  assign cause_clr = (wr_en && paddr == OFS_CAUSE) ?
                     pwdata[CAUSE_W-1:0] : '0;  // see [R9]

  src_flags #(
    .WIDTH (CAUSE_W)
  ) u_cause (
    .clk      (clk),
    .rst_b    (rst_b),
    .load     (evt && (kind == SRC_POR || kind == SRC_LVR)),  // see [R2]
    .load_val (CAUSE_PWRUP),
    .set      (cause_set),  // see [R2]
    .clr      (cause_clr),
    .flags    (cause)
  );

  // Software reset requests, consumed when the reset is taken
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      chip_req_reg  <= CHIPREQ_RST;
      chip_pend_reg <= 1'b0;
      mcu_pend_reg  <= 1'b0;
      cpu_pend_reg  <= 1'b0;
    end
    else
    begin
      if (evt && kind == SRC_POR)
        chip_req_reg <= CHIPREQ_RST;  // see [R3]
      else if (wr_en && paddr == OFS_SWRST)
        chip_req_reg <= pwdata[SW_CHIP];
      if (wr_en && paddr == OFS_SWRST)
      begin
        chip_pend_reg <= chip_pend_reg | pwdata[SW_CHIP];
        mcu_pend_reg  <= mcu_pend_reg | pwdata[SW_MCU];
        cpu_pend_reg  <= cpu_pend_reg | pwdata[SW_CPU];
      end
      else if (evt)
      begin
        // A CPU-only reset must not swallow a pending system request
        chip_pend_reg <= (kind == SRC_CPU) & chip_pend_reg;
        mcu_pend_reg  <= (kind == SRC_CPU) & mcu_pend_reg;
        cpu_pend_reg  <= 1'b0;
      end
    end
  end

  // Brown-out fields
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      brownout_enable       <= 1'b0;
      brownout_level        <= 2'h0;
      brownout_reset_enable <= 1'b0;
    end
    else if (evt && kind != SRC_BOD && kind != SRC_CPU)
    begin
      brownout_enable       <= cfg_brownout_enable;  // see [R4]
      brownout_level        <= cfg_brownout_level;
      brownout_reset_enable <= cfg_brownout_reset_enable;
    end
    else if (wr_en && paddr == OFS_BODCTL)
    begin
      brownout_enable       <= pwdata[BOD_EN];
      brownout_level        <= pwdata[BOD_LVL_LO +: 2];
      brownout_reset_enable <= pwdata[BOD_RSTEN];
    end
  end

  // Clock control fields
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      crystal_enable             <= XTAL_RST;
      system_clock_source_select <= CLKSEL_RST;
      watchdog_clock_enable      <= WDTCK_RST;
    end
    else
    begin
      if (evt && kind != SRC_CPU)
      begin
        crystal_enable             <= XTAL_RST;  // see [R5]
        system_clock_source_select <= CLKSEL_RST;  // see [R7]
      end
      else if (wr_en && paddr == OFS_CLKCTL)
      begin
        crystal_enable             <= pwdata[CLK_XTAL_LO +: 2];
        system_clock_source_select <= pwdata[CLK_SEL_LO +: CLKSEL_W];
      end
      if (evt && (kind == SRC_POR || kind == SRC_WDT || kind == SRC_CHIP))
        watchdog_clock_enable <= WDTCK_RST;  // see [R6]
      else if (wr_en && paddr == OFS_CLKCTL)
        watchdog_clock_enable <= pwdata[CLK_WDT];
    end
  end

  // APB slave: one wait-free access phase, read data latched at setup
  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pwrite && pready;
  assign mapped = (paddr == OFS_CAUSE) || (paddr == OFS_MASK) ||
                  (paddr == OFS_SWRST) || (paddr == OFS_BODCTL) ||
                  (paddr == OFS_CLKCTL) || (paddr == OFS_STATUS);

  always_comb
  begin
    rdata = 32'h0000_0000;
    case (paddr)
      OFS_CAUSE:  rdata[CAUSE_W-1:0] = cause;
      OFS_MASK:   rdata[CAUSE_W-1:0] = mask_reg;
      OFS_SWRST:  rdata[SW_CHIP]     = chip_req_reg;
      OFS_BODCTL:
      begin
        rdata[BOD_EN]         = brownout_enable;
        rdata[BOD_LVL_LO +: 2] = brownout_level;
        rdata[BOD_RSTEN]      = brownout_reset_enable;
      end
      OFS_CLKCTL:
      begin
        rdata[CLK_XTAL_LO +: 2]       = crystal_enable;
        rdata[CLK_SEL_LO +: CLKSEL_W] = system_clock_source_select;
        rdata[CLK_WDT]                = watchdog_clock_enable;
      end
      OFS_STATUS:
      begin
        rdata[0]   = core_reset_b;
        rdata[1]   = periph_reset_b;
        rdata[2]   = lv_filt;
        rdata[6:4] = state_reg;
      end
      default:    rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup)
        prdata <= rdata;
    end
  end

  // Interrupt mask and output
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      mask_reg <= '0;
    else if (wr_en && paddr == OFS_MASK)
      mask_reg <= pwdata[CAUSE_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(cause & mask_reg);
  end

endmodule
`default_nettype wire

// >>> src_top_properties.sv
// Port-level checker for the system reset controller
`default_nettype none
`timescale 1ns/10ps
module src_top_properties
  import src_pkg::*;
#(
  parameter int HOLD_CYC = RESET_HOLD_CYC,
  parameter int DEGLITCH = DEGLITCH_CYC
)
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       supply_ready,
  input wire logic       low_supply,
  input wire logic       external_reset_pin_b,
  input wire logic       wdt_reset,
  input wire logic       bod_reset,
  input wire logic       cfg_brownout_enable,
  input wire logic       core_reset_b,
  input wire logic       periph_reset_b,
  input wire logic       brownout_enable,
  input wire logic [1:0] crystal_enable,
  input wire logic [3:0] system_clock_source_select
);
  logic [7:0] lo_cnt;
  logic [7:0] ok_cnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Run lengths of the raw level; good level starts saturated
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      lo_cnt <= 8'h00;
      ok_cnt <= 8'hff;
    end
    else
    begin
      lo_cnt <= low_supply ? lo_cnt + {7'h00, lo_cnt != 8'hff} : 8'h00;
      ok_cnt <= low_supply ? 8'h00 : ok_cnt + {7'h00, ok_cnt != 8'hff};
    end
  end

  property p_pready;
    psel && !penable |=> pready;
  endproperty
  property p_core_only;
    !periph_reset_b |-> !core_reset_b;
  endproperty
  property p_pin;
    !external_reset_pin_b |=> !periph_reset_b && !core_reset_b;
  endproperty
  property p_wdt;
    wdt_reset && core_reset_b && periph_reset_b |=> !periph_reset_b;
  endproperty
  property p_supply;
    !supply_ready |=> !core_reset_b && !periph_reset_b;
  endproperty
  property p_lv_set;
    lo_cnt == DEGLITCH + 1 |-> !periph_reset_b;
  endproperty
  property p_lv_rel;
    $rose(periph_reset_b) |-> ok_cnt > DEGLITCH;
  endproperty
  property p_fields;
    $fell(periph_reset_b) |-> ##[0:2]
      (crystal_enable == 2'h0 && system_clock_source_select == 4'h8);
  endproperty
  property p_bod;
    $fell(periph_reset_b) && !$past(bod_reset) && !bod_reset |-> ##[0:2]
      (brownout_enable == cfg_brownout_enable);
  endproperty

  a_pready: assert property (p_pready)
    else $error("no access answer after setup");
  a_core_only: assert property (p_core_only)
    else $error("peripherals reset without core");
  a_pin: assert property (p_pin)
    else $error("pin low without reset");
  a_wdt: assert property (p_wdt)
    else $error("watchdog request not taken");
  a_supply: assert property (p_supply)
    else $error("reset released without supply");
  a_lv_set: assert property (p_lv_set)
    else $error("low supply not acted on");
  a_lv_rel: assert property (p_lv_rel)
    else $error("reset released too soon after low supply");
  a_fields: assert property (p_fields)
    else $error("clock fields not reset");
  a_bod: assert property (p_bod)
    else $error("brown-out enable not reloaded");

  c_cpu: cover property (!core_reset_b && periph_reset_b);
  c_lv: cover property (lo_cnt == DEGLITCH + 1);
  c_pin: cover property ($rose(external_reset_pin_b));
endmodule

bind src_top src_top_properties #(.HOLD_CYC(HOLD_CYC), .DEGLITCH(DEGLITCH))
  u_props (.clk, .rst_b, .psel, .penable, .pready, .supply_ready,
           .low_supply, .external_reset_pin_b, .wdt_reset, .bod_reset,
           .cfg_brownout_enable, .core_reset_b, .periph_reset_b,
           .brownout_enable, .crystal_enable, .system_clock_source_select);
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench for the system reset controller
`default_nettype none
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tb_top
  import src_pkg::*;
;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic        supply_ready, low_supply, pin_b, wdt_r, bod_r, lockup;
  logic        core_b, per_b, bo_en, bo_rst, wdt_ck, irq;
  logic        per_seen, core_seen;
  logic [1:0]  bo_lvl, xtal;
  logic [3:0]  clksel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, compares;

  src_top dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_ready(supply_ready),
    .low_supply(low_supply), .external_reset_pin_b(pin_b),
    .wdt_reset(wdt_r), .bod_reset(bod_r), .core_lockup(lockup),
    .cfg_brownout_enable(1'b1), .cfg_brownout_level(2'h2),
    .cfg_brownout_reset_enable(1'b1), .core_reset_b(core_b),
    .periph_reset_b(per_b), .brownout_enable(bo_en),
    .brownout_level(bo_lvl), .brownout_reset_enable(bo_rst),
    .crystal_enable(xtal), .watchdog_clock_enable(wdt_ck),
    .system_clock_source_select(clksel), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Sticky record of reset pulses between checks
  always @(posedge clk)
  begin
    if (per_b === 1'b0) per_seen <= 1'b1;
    if (core_b === 1'b0) core_seen <= 1'b1;
  end

  task close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n == 16) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait until both resets are released
  task wait_run;
    int n;
    repeat (3) @(posedge clk);
    n = 0;
    while (!(core_b === 1'b1 && per_b === 1'b1) && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 200) n_mismatch++;
  endtask

  task t_por;
    repeat (10) @(posedge clk);
    `CHK("core_rst", 1'b0, core_b)
    `CHK("per_rst", 1'b0, per_b)
    supply_ready <= 1'b1;
    wait_run;
    apb(1'b0, OFS_CAUSE, 32'h0);
    `CHK("cause", 32'h001, rd)
    apb(1'b0, OFS_CLKCTL, 32'h0);
    `CHK("clkctl", 32'h180, rd)
    `CHK("bod_out", 4'hd, {bo_rst, bo_lvl, bo_en})
    apb(1'b1, OFS_CAUSE, 32'h0);
    apb(1'b0, OFS_CAUSE, 32'h0);
    `CHK("cause_w0", 32'h001, rd)
    apb(1'b1, OFS_CAUSE, 32'h1);
    apb(1'b0, OFS_CAUSE, 32'h0);
    `CHK("cause_w1", 32'h000, rd)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    $display("test por done");
  endtask

  // Order: chip last, since software writes clear the request bit
  task t_src(input int k);
    logic [8:0] ec;
    apb(1'b1, OFS_CLKCTL, 32'h023);
    apb(1'b1, OFS_BODCTL, 32'h000);
    per_seen = 1'b0;
    core_seen = 1'b0;
    case (k)
      0: ec = 9'h004;
      1: ec = 9'h010;
      2: ec = 9'h100;
      3: ec = 9'h020;
      4: ec = 9'h080;
      default: ec = 9'h001;
    endcase
    case (k)
      0: wdt_r <= 1'b1;
      1: bod_r <= 1'b1;
      2: lockup <= 1'b1;
      3: apb(1'b1, OFS_SWRST, 32'h002);
      4: apb(1'b1, OFS_SWRST, 32'h004);
      default: apb(1'b1, OFS_SWRST, 32'h001);
    endcase
    repeat (2) @(posedge clk);
    wdt_r <= 1'b0;
    bod_r <= 1'b0;
    lockup <= 1'b0;
    wait_run;
    apb(1'b0, OFS_CAUSE, 32'h0);
    `CHK("cause", {23'h0, ec}, rd)
    apb(1'b1, OFS_CAUSE, 32'h1ff);
    apb(1'b0, OFS_CLKCTL, 32'h0);
    `CHK("clkctl", k == 4 ? 32'h023 : k == 0 || k == 5 ? 32'h180 : 32'h080, rd)
    `CHK("bod_out", k == 1 || k == 4 ? 4'h0 : 4'hd, {bo_rst, bo_lvl, bo_en})
    `CHK("per_seen", k != 4, per_seen)
    `CHK("core_seen", 1'b1, core_seen)
    apb(1'b0, OFS_SWRST, 32'h0);
    `CHK("chip_req", k == 5, rd[0])
    $display("test source %0d done", k);
  endtask

  task t_pin;
    apb(1'b1, OFS_MASK, 32'h002);
    pin_b <= 1'b0;
    repeat (5) @(posedge clk);
    pin_b <= 1'b1;
    wait_run;
    `CHK("irq_set", 1'b1, irq)
    apb(1'b0, OFS_CAUSE, 32'h0);
    `CHK("cause", 32'h002, rd)
    apb(1'b1, OFS_MASK, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq_mask", 1'b0, irq)
    apb(1'b1, OFS_MASK, 32'h002);
    repeat (2) @(posedge clk);
    `CHK("irq_unmask", 1'b1, irq)
    apb(1'b1, OFS_CAUSE, 32'h002);
    repeat (2) @(posedge clk);
    `CHK("irq_clr", 1'b0, irq)
    apb(1'b0, OFS_SWRST, 32'h0);
    `CHK("chip_req", 1'b1, rd[0])
    $display("test pin done");
  endtask

  task t_lvr;
    per_seen = 1'b0;
    low_supply <= 1'b1;
    repeat (15) @(posedge clk);
    low_supply <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK("glitch", 1'b0, per_seen)
    low_supply <= 1'b1;
    repeat (18) @(posedge clk);
    `CHK("lv_rst", 1'b0, per_b)
    low_supply <= 1'b0;
    repeat (10) @(posedge clk);
    low_supply <= 1'b1;
    @(posedge clk);
    low_supply <= 1'b0;
    repeat (14) @(posedge clk);
    `CHK("lv_hold", 1'b0, per_b)
    wait_run;
    apb(1'b0, OFS_CAUSE, 32'h0);
    `CHK("cause", 32'h001, rd)
    $display("test lvr done");
  endtask

  initial
  begin
    {rst_b, psel, penable, pwrite, supply_ready, low_supply} = 6'h0;
    {wdt_r, bod_r, lockup, per_seen, core_seen} = 5'h0;
    pin_b = 1'b1;
    paddr = 12'h0;
    pwdata = 32'h0;
    n_mismatch = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_por;
    for (int k = 0; k < 6; k++) t_src(k);
    t_pin;
    t_lvr;
    close_out;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
endmodule
`default_nettype wire
